// >>> hw/sdl_map.svh
/*
  Constants of the serial DAC load control block: register offsets, field
  positions, reset values and counts.
  Assumes it is included by bare name wherever one of these is needed.
*/
`ifndef SDL_MAP_SVH
`define SDL_MAP_SVH

// Register byte offsets on the Avalon-MM slave.
`define SDL_OFS_CTRL 4'h0
`define SDL_OFS_STATUS 4'h4
`define SDL_OFS_LATCH 4'h8
`define SDL_OFS_SHIFT 4'hC

// Control register fields.
`define SDL_CTRL_SW_LOAD 0
`define SDL_CTRL_HOLD_CLAMP 1
`define SDL_CTRL_RST 2'h0

// Status register fields.
`define SDL_ST_CLAMP 0
`define SDL_ST_AUTO 1
`define SDL_ST_FRAME 2
`define SDL_ST_FULL 3
`define SDL_ST_SUPPLY 4
`define SDL_ST_CNT_LSB 8

// Serial word length and counter width.
`define SDL_WORD_BITS 16
`define SDL_CNT_BITS 5
`define SDL_WORD_LAST 5'h0F
`define SDL_WORD_DONE 5'h10

// Reset values.
`define SDL_WORD_RST 16'h0000
`define SDL_CLEAR_WORD 16'h0000
// Chain enable (bit 6) resets low so the chain output is not driven after reset.
`define SDL_PIN_IDLE 8'hBF

`endif

// >>> hw/sdl_pkg.sv
/*
  Types of the serial DAC load control block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package sdl_pkg;

  // Frame state: waiting for a frame, shifting, word complete.
  typedef enum logic [2:0] {
    SDL_IDLE = 3'h1,
    SDL_SHIFT = 3'h2,
    SDL_FULL = 3'h4
  } sdl_state_t;

  typedef logic [15:0] sdl_word_t;

endpackage : sdl_pkg

// >>> hw/sdl_sync.sv
/*
  Three-stage synchroniser for a group of asynchronous pins.
  Assumes each bit is a slow level from outside the clk domain.
*/
`timescale 1ns/1ps
`default_nettype none

module sdl_sync #(
  parameter int W = 8,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Pins in, filtered level out.
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level_out
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] level_next;

  // A change is accepted only once the second and third stages agree.
  // The first stage feeds the second stage and nothing else.
  assign level_next = (s2_reg & ~(s2_reg ^ s3_reg)) | (level_out & (s2_reg ^ s3_reg));

  // Shift chain and filtered output.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
      s3_reg <= RST_VAL;
      level_out <= RST_VAL;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      level_out <= level_next;
    end
  end

endmodule : sdl_sync

`default_nettype wire

// >>> hw/sdl_regs.sv
/*
  Avalon-MM register slave of the serial DAC load control block.
  Assumes a master that holds each request until waitrequest is seen low.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sdl_map.svh"

module sdl_regs (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Avalon-MM slave.
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Block state to read.
  input wire logic [31:0] status_word,
  input wire sdl_pkg::sdl_word_t latch_word,
  input wire sdl_pkg::sdl_word_t shift_word,
  // Control to the block.
  output logic sw_load,
  output logic hold_clamp
);
  import sdl_pkg::*;

  logic [1:0] ctrl_reg;
  logic [31:0] rd_sel;
  logic wr_go;
  wire sel_ctrl = (avs_address == `SDL_OFS_CTRL);
  wire sel_status = (avs_address == `SDL_OFS_STATUS);
  wire sel_latch = (avs_address == `SDL_OFS_LATCH);
  wire sel_shift = (avs_address == `SDL_OFS_SHIFT);

  // Read mux; unmapped offsets read as zero.
  assign rd_sel = sel_ctrl ? {30'h0, ctrl_reg} :
                  sel_status ? status_word :
                  sel_latch ? {16'h0000, latch_word} :
                  sel_shift ? {16'h0000, shift_word} : 32'h0;
  // A write lands at the edge where the master sees waitrequest low.
  assign wr_go = avs_write & ~avs_waitrequest;
  assign hold_clamp = ctrl_reg[`SDL_CTRL_HOLD_CLAMP];

  // One wait state per access keeps every output a flip-flop.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
      ctrl_reg <= `SDL_CTRL_RST;
      sw_load <= 1'b0;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      if (avs_read & avs_waitrequest) begin
        avs_readdata <= rd_sel;
      end
      sw_load <= wr_go & sel_ctrl & avs_writedata[`SDL_CTRL_SW_LOAD];
      if (wr_go & sel_ctrl) begin
        ctrl_reg <= {avs_writedata[`SDL_CTRL_HOLD_CLAMP], 1'b0};
      end
    end
  end

endmodule : sdl_regs

`default_nettype wire

// >>> hw/sdl_top.sv
/*
  Serial DAC load control: three-wire input link, shift register, DAC
  latch, update modes, clear, external reset and supply monitor output.
  Assumes all link and strobe pins are asynchronous to clk and change
  much slower than clk (link clock period of several clk periods).
*/
`timescale 1ns/1ps
`default_nettype none
`include "sdl_map.svh"

// Overview of operation
// R1: Load strobe falling edge copies the shifted word into the DAC latch.
// R2: Load strobe low at frame start selects update on the 16th clock fall.
// R3: Each frame carries one 16-bit word; only sixteen bits are taken standalone.
// R4: Clear low forces the zero word, giving 0 V or reference per coding.
// R5: External reset low clamps the output to 0 V until reloaded.
// R6: The outside party keeps external reset high in normal use.
// R7: Supply monitor state is driven out on its own pin.
// R8: One code step is span over 2^16, or 2^14 for the reduced variant.
// R9: In bipolar use the word with only the top bit set means 0 V.
// R10: Frame sync high deselects the device; link activity is ignored.
// R11: Frame sync falling edge restarts the input logic for a new word.
// R12: One bit shifts in on every falling serial clock edge.
// R13: Chain enable high drives the chain output, shifted on rising edges.
// R14: Format select low means binary, high means twos complement.
// R15: The latch holds its value until an update event.
module sdl_top #(
  parameter int RES_BITS = 16
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Avalon-MM slave.
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Serial link.
  input wire logic frame_sync_n,
  input wire logic serial_clk,
  input wire logic serial_data_in,
  // Chain output.
  input wire logic chain_enable,
  output logic chain_data_out,
  output logic chain_data_oe,
  // Strobes and static pins.
  input wire logic load_strobe_n,
  input wire logic clear_n,
  input wire logic external_reset_n,
  input wire logic code_format_select,
  input wire logic supply_good,
  // Output code and status.
  output logic [RES_BITS-1:0] analog_output_code,
  output logic analog_output_clamp,
  output logic supply_monitor_out
);
  import sdl_pkg::*;

  // Synchronised pins.
  logic [7:0] pins_raw;
  logic [7:0] pins;
  wire fs_n = pins[0];
  wire sck = pins[1];
  wire sdi = pins[2];
  wire ld_n = pins[3];
  wire clear_lvl_n = pins[4];
  wire ext_rst_n = pins[5];
  wire chain_en = pins[6];
  wire supply_ok = pins[7];
  logic fmt_twos;

  // Edge history of synchronised levels.
  logic fs_n_d_reg;
  logic sck_d_reg;
  logic ld_n_d_reg;

  // Frame and data state.
  sdl_state_t state_reg;
  sdl_state_t state_next;
  logic [`SDL_CNT_BITS-1:0] cnt_reg;
  logic [`SDL_CNT_BITS-1:0] cnt_next;
  sdl_word_t shift_reg;
  sdl_word_t shift_next;
  sdl_word_t latch_reg;
  sdl_word_t latch_next;
  logic auto_reg;
  logic auto_next;
  logic clamp_reg;
  logic clamp_next;
  logic chain_out_reg;
  logic [RES_BITS-1:0] code_next;
  sdl_word_t offset_word;

  // Register slave wires.
  logic sw_load;
  logic hold_clamp;
  logic [31:0] status_word;

  // Converts a stored word to offset-binary form for the output stage.
  function automatic sdl_word_t to_offset(input sdl_word_t w, input logic twos);
    to_offset = {w[15] ^ twos, w[14:0]}; // see R14 see R9
  endfunction : to_offset

  // All pins arrive from outside the clk domain.
  assign pins_raw = {supply_good, chain_enable, external_reset_n, clear_n,
                     load_strobe_n, serial_data_in, serial_clk, frame_sync_n};

  sdl_sync #(
    .W(8),
    .RST_VAL(`SDL_PIN_IDLE)
  ) u_sync (
    .clk(clk),
    .rstn(rstn),
    .pin_in(pins_raw),
    .level_out(pins)
  );

  // The format pin idles low, so it has a synchroniser of its own.
  sdl_sync #(
    .W(1),
    .RST_VAL(1'b0)
  ) u_sync_fmt (
    .clk(clk),
    .rstn(rstn),
    .pin_in(code_format_select),
    .level_out(fmt_twos)
  );

  sdl_regs u_regs (
    .clk(clk),
    .rstn(rstn),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .status_word(status_word),
    .latch_word(latch_reg),
    .shift_word(shift_reg),
    .sw_load(sw_load),
    .hold_clamp(hold_clamp)
  );

  // Edge events, all seen on synchronised levels.
  wire fs_fall = fs_n_d_reg & ~fs_n;
  wire sck_fall = sck_d_reg & ~sck;
  wire sck_rise = ~sck_d_reg & sck;
  wire ld_fall = ld_n_d_reg & ~ld_n;
  wire selected = ~fs_n; // see R10

  // Standalone mode gates the clock after sixteen bits; chain mode never does.
  wire gate_open = chain_en | (cnt_reg != `SDL_WORD_DONE); // see R3
  wire take_bit = selected & ~fs_fall & sck_fall & gate_open; // see R12 see R10
  wire last_bit = take_bit & (cnt_reg == `SDL_WORD_LAST); // see R3
  wire auto_update = last_bit & auto_reg; // see R2
  wire strobe_update = ld_fall | sw_load; // see R1
  wire any_update = auto_update | strobe_update;

  // Frame state machine.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SDL_IDLE: begin
        if (fs_fall) begin
          state_next = SDL_SHIFT; // see R11
        end
      end
      SDL_SHIFT: begin
        if (fs_n) begin
          state_next = SDL_IDLE; // see R10
        end else if (last_bit & ~chain_en) begin
          state_next = SDL_FULL;
        end
      end
      SDL_FULL: begin
        if (fs_n) begin
          state_next = SDL_IDLE;
        end else if (fs_fall) begin
          state_next = SDL_SHIFT;
        end
      end
      default: begin
        state_next = SDL_IDLE;
      end
    endcase
  end

  // Bit counter saturates at sixteen; a new frame restarts it.
  always_comb begin
    cnt_next = cnt_reg;
    if (fs_fall) begin
      cnt_next = '0; // see R11
    end else if (take_bit & (cnt_reg != `SDL_WORD_DONE)) begin
      cnt_next = cnt_reg + `SDL_CNT_BITS'(1);
    end
  end

  // Update mode is fixed by the load strobe level at frame start.
  assign auto_next = fs_fall ? ~ld_n : auto_reg; // see R2

  // Shift register takes serial data MSB first.
  assign shift_next = take_bit ? {shift_reg[14:0], sdi} : shift_reg; // see R12

  // Latch: clear dominates, then any update, otherwise hold.
  // The shifted-in word is used on auto update so the last bit is included.
  always_comb begin
    latch_next = latch_reg; // see R15
    if (!clear_lvl_n) begin
      latch_next = `SDL_CLEAR_WORD; // see R4
    end else if (auto_update) begin
      latch_next = shift_next; // see R2
    end else if (strobe_update) begin
      latch_next = shift_reg; // see R1
    end
  end

  // The clamp sets on reset, external reset or a failing supply, and is
  // released only by a fresh load while those are all inactive. Software
  // may also hold it set.
  always_comb begin
    clamp_next = clamp_reg;
    if (!ext_rst_n | !supply_ok | hold_clamp) begin
      clamp_next = 1'b1; // see R5 see R6
    end else if (any_update) begin
      clamp_next = 1'b0;
    end
  end

  // Output code: top RES_BITS of the offset-binary word, so one step is the
  // span over 2 to the RES_BITS. Clamp forces zero volts regardless of code.
  assign offset_word = to_offset(latch_next, fmt_twos); // see R14
  assign code_next = offset_word[15 -: RES_BITS]; // see R8 see R9

  // Status word readable by software.
  assign status_word = {19'h0, cnt_reg, 3'h0, supply_ok, (state_reg == SDL_FULL),
                        selected, auto_reg, clamp_reg};

  // Edge history.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fs_n_d_reg <= 1'b1;
      sck_d_reg <= 1'b1;
      ld_n_d_reg <= 1'b1;
    end else begin
      fs_n_d_reg <= fs_n;
      sck_d_reg <= sck;
      ld_n_d_reg <= ld_n;
    end
  end

  // Frame and data registers. The clamp starts set, as at power-up.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= SDL_IDLE;
      cnt_reg <= '0;
      auto_reg <= 1'b0;
      shift_reg <= `SDL_WORD_RST;
      latch_reg <= `SDL_WORD_RST;
      clamp_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      auto_reg <= auto_next;
      shift_reg <= shift_next;
      latch_reg <= latch_next;
      clamp_reg <= clamp_next;
    end
  end

  // Chain output shifts on rising serial clock edges while selected.
  // Disabled, it rests low so a following device sees a quiet line.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      chain_out_reg <= 1'b0;
    end else if (!chain_en) begin
      chain_out_reg <= 1'b0;
    end else if (selected & sck_rise) begin
      chain_out_reg <= shift_reg[15]; // see R13
    end
  end

  // Registered pin outputs.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      chain_data_out <= 1'b0;
      chain_data_oe <= 1'b0;
      analog_output_code <= '0;
      analog_output_clamp <= 1'b1;
      supply_monitor_out <= 1'b0;
    end else begin
      chain_data_out <= chain_out_reg;
      chain_data_oe <= chain_en; // see R13
      analog_output_code <= clamp_next ? '0 : code_next;
      analog_output_clamp <= clamp_next; // see R5
      supply_monitor_out <= supply_ok; // see R7
    end
  end

endmodule : sdl_top

`default_nettype wire

// >>> dv/sdl_asserts.sv
/*
  Port checker for sdl_top, bound from the bench.
  Assumes pin levels pass a synchroniser of about five clk edges.
*/
`timescale 1ns/1ps
`default_nettype none

module sdl_asserts #(
  parameter int RES_BITS = 16
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Inputs watched.
  input wire logic avs_write,
  input wire logic frame_sync_n,
  input wire logic load_strobe_n,
  input wire logic clear_n,
  input wire logic external_reset_n,
  input wire logic code_format_select,
  input wire logic supply_good,
  input wire logic chain_enable,
  // Outputs watched.
  input wire logic chain_data_out,
  input wire logic chain_data_oe,
  input wire logic [RES_BITS-1:0] analog_output_code,
  input wire logic analog_output_clamp,
  input wire logic supply_monitor_out
);
  // Windows of seven or eight cycles cover the pin synchroniser latency.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_mon; $fell(supply_good) |-> ##[1:7] !supply_monitor_out; endproperty
  a_mon: assert property (p_mon) else $error("monitor missed low");
  property p_rst; $fell(external_reset_n) |-> ##[1:7] analog_output_clamp; endproperty
  a_rst: assert property (p_rst) else $error("no clamp on reset");
  property p_cz; analog_output_clamp && $past(analog_output_clamp) |-> analog_output_code == '0; endproperty
  a_cz: assert property (p_cz) else $error("code while clamped");
  property p_clr; (!clear_n && !code_format_select) [*8] |-> analog_output_code == '0; endproperty
  a_clr: assert property (p_clr) else $error("clear not zero");
  property p_clt;
    (!clear_n && code_format_select && !analog_output_clamp) [*8]
      |-> analog_output_code == {1'b1, {(RES_BITS-1){1'b0}}};
  endproperty
  a_clt: assert property (p_clt) else $error("clear not midscale");
  property p_oe; chain_enable [*8] |-> chain_data_oe; endproperty
  a_oe: assert property (p_oe) else $error("chain not driven");
  property p_noe; (!chain_enable) [*8] |-> !chain_data_oe && !chain_data_out; endproperty
  a_noe: assert property (p_noe) else $error("chain driven");
  // A latch change needs a strobe, a frame, a clear, a write or a clamp cause.
  property p_hold;
    (frame_sync_n && load_strobe_n && clear_n && external_reset_n && supply_good && !avs_write
      && $stable(code_format_select)) [*8] |=> $stable(analog_output_code);
  endproperty
  a_hold: assert property (p_hold) else $error("code moved idle");
endmodule : sdl_asserts

`default_nettype wire

// >>> dv/sdl_host_model.sv
/*
  Host model: drives the three-wire link and load strobe, captures chain output.
  Assumes one bench process calls its tasks, one at a time.
*/
`timescale 1ns/1ps
`default_nettype none

module sdl_host_model (
  // Link and strobe driven.
  output var logic frame_sync_n,
  output var logic serial_clk,
  output var logic serial_data_in,
  output var logic load_strobe_n,
  // Chain return.
  input wire logic chain_data_out
);
  logic [15:0] rx = 16'h0000;

  // Idle link: deselected, clock parked high.
  initial begin
    frame_sync_n = 1'b1;
    serial_clk = 1'b1;
    serial_data_in = 1'b0;
    load_strobe_n = 1'b1;
  end

  // Sends n bits MSB first; the strobe level at frame start picks the mode.
  task automatic send(input logic [31:0] w, input int n, input logic sel, input logic au);
    // Link pins move off the clk edge, so the synchroniser never races them.
    #5;
    load_strobe_n = !au;
    #200 frame_sync_n = !sel;
    for (int i = 0; i < n; i++) begin
      serial_data_in = w[n-1-i];
      #100 serial_clk = 1'b0;
      #100 rx = (i >= 16) ? {rx[14:0], chain_data_out} : rx;
      serial_clk = 1'b1;
    end
    #100 frame_sync_n = 1'b1;
    // Released data shows the inverse so a stale bit cannot pass.
    serial_data_in = ~serial_data_in;
    load_strobe_n = 1'b1;
    #400;
  endtask : send

  // A 1 us low pulse; the latch loads on its falling edge.
  task automatic pulse();
    #5;
    load_strobe_n = 1'b0;
    #1000 load_strobe_n = 1'b1;
    #400;
  endtask : pulse
endmodule : sdl_host_model

`default_nettype wire

// >>> dv/sdl_tb_top.sv
/*
  Bench of sdl_top: Avalon tasks, host link model and checks.
  Assumes sdl_top, sdl_host_model and sdl_asserts are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sdl_map.svh"

module sdl_tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat, r;
  logic wreq, fs_n, sck, sdi, ld_n, cdo, coe, clamp, mon;
  logic [15:0] code;
  logic cen = 1'b0;
  logic clr_n = 1'b1;
  logic ext_n = 1'b1;
  logic fmt = 1'b0;
  logic sup = 1'b1;
  int bad_count = 0;
  int samples_checked = 0;

  // Free-running 40 MHz clock.
  always #12.5 clk = ~clk;

  sdl_top #(.RES_BITS(16)) sdl_top_i (.clk(clk), .rstn(rstn), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wreq),
    .frame_sync_n(fs_n), .serial_clk(sck), .serial_data_in(sdi), .chain_enable(cen),
    .chain_data_out(cdo), .chain_data_oe(coe), .load_strobe_n(ld_n), .clear_n(clr_n),
    .external_reset_n(ext_n), .code_format_select(fmt), .supply_good(sup),
    .analog_output_code(code), .analog_output_clamp(clamp), .supply_monitor_out(mon));
  sdl_host_model sdl_host_model_i (.frame_sync_n(fs_n), .serial_clk(sck), .serial_data_in(sdi),
    .load_strobe_n(ld_n), .chain_data_out(cdo));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  // One access held until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    r = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50) chk(32'h0, 32'h1);
  endtask : bus

  task automatic rdc(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(r, e);
  endtask : rdc

  task automatic settle();
    repeat (10) @(posedge clk);
  endtask : settle

  task automatic complete_run();
    $display("checked %0d bad %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  // Main sequence; expected codes follow from the words sent.
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    settle();
    chk(clamp, 1'b1);
    chk(mon, 1'b1);
    rdc(`SDL_OFS_LATCH, 32'h0);
    rdc(4'h2, 32'h0);
    rdc(`SDL_OFS_STATUS, 32'h11);
    sdl_host_model_i.send(32'hA5C3, 16, 1'b1, 1'b0);
    settle();
    chk(code, 16'h0000);
    rdc(`SDL_OFS_STATUS, 32'h1011);
    rdc(`SDL_OFS_SHIFT, 32'hA5C3);
    sdl_host_model_i.pulse();
    settle();
    chk(code, 16'hA5C3);
    chk(clamp, 1'b0);
    sdl_host_model_i.send(32'h5A5A, 16, 1'b0, 1'b0);
    rdc(`SDL_OFS_SHIFT, 32'hA5C3);
    sdl_host_model_i.send(32'h1234F, 20, 1'b1, 1'b1);
    settle();
    chk(code, 16'h1234);
    sdl_host_model_i.send(32'h8000, 16, 1'b1, 1'b1);
    settle();
    chk(code, 16'h8000);
    ext_n <= 1'b0;
    settle();
    chk(code, 16'h0000);
    ext_n <= 1'b1;
    settle();
    chk(clamp, 1'b1);
    sdl_host_model_i.pulse();
    settle();
    chk(code, 16'h8000);
    fmt <= 1'b1;
    settle();
    chk(code, 16'h0000);
    clr_n <= 1'b0;
    settle();
    rdc(`SDL_OFS_LATCH, 32'h0);
    chk(code, 16'h8000);
    fmt <= 1'b0;
    settle();
    chk(code, 16'h0000);
    clr_n <= 1'b1;
    sup <= 1'b0;
    settle();
    chk(mon, 1'b0);
    chk(clamp, 1'b1);
    sup <= 1'b1;
    cen <= 1'b1;
    settle();
    chk(coe, 1'b1);
    sdl_host_model_i.send(32'hBEEF1357, 32, 1'b1, 1'b0);
    chk(sdl_host_model_i.rx, 16'hBEEF);
    sdl_host_model_i.pulse();
    settle();
    chk(code, 16'h1357);
    cen <= 1'b0;
    settle();
    chk(coe, 1'b0);
    // A soft load from software must release the clamp like a strobe fall.
    ext_n <= 1'b0;
    settle();
    ext_n <= 1'b1;
    settle();
    chk(clamp, 1'b1);
    bus(1'b1, `SDL_OFS_CTRL, 32'h1);
    settle();
    chk(clamp, 1'b0);
    chk(code, 16'h1357);
    bus(1'b1, `SDL_OFS_CTRL, 32'h2);
    rdc(`SDL_OFS_CTRL, 32'h2);
    complete_run();
  end

  // Watchdog well beyond the expected run of about 34 us.
  initial begin
    #300us;
    bad_count++;
    complete_run();
  end
endmodule : sdl_tb_top

bind sdl_top sdl_asserts #(.RES_BITS(RES_BITS)) sdl_asserts_i (.clk(clk), .rstn(rstn),
  .avs_write(avs_write), .frame_sync_n(frame_sync_n), .load_strobe_n(load_strobe_n),
  .clear_n(clear_n), .external_reset_n(external_reset_n), .code_format_select(code_format_select),
  .supply_good(supply_good), .chain_enable(chain_enable), .chain_data_out(chain_data_out),
  .chain_data_oe(chain_data_oe), .analog_output_code(analog_output_code),
  .analog_output_clamp(analog_output_clamp), .supply_monitor_out(supply_monitor_out));

`default_nettype wire
